/* common/pcc_pkg.sv */
package pcc_pkg;

  // clock and cycle timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_SETUP_NS = 30;
  localparam int T_STROBE_NS = 150;
  localparam int T_HOLD_NS = 30;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // widths
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;

  // strap encodings for the shared pin group
  localparam logic [1:0] STRAP_ISA = 2'h0;
  localparam logic [1:0] STRAP_LOCAL = 2'h1;
  localparam logic [1:0] STRAP_PCCARD = 2'h2;

  // positions in the synchronised pin vector
  localparam int SYN_W = 8;
  localparam int SYN_WAIT = 0;
  localparam int SYN_READY = 1;
  localparam int SYN_DET_A = 2;
  localparam int SYN_DET_B = 3;
  localparam int SYN_BAT_A = 4;
  localparam int SYN_BAT_B = 5;
  localparam int SYN_WP = 6;
  localparam int SYN_MASTER = 7;
  // idle pin levels: no wait, ready, no card, battery good, unprotected, no master
  localparam logic [SYN_W-1:0] SYN_RST = 8'hbf;

  // power select reset value: vcc off, vpp selects at zero
  localparam logic VCC_OFF = 1'b1;
  localparam logic [1:0] VPP_OFF = 2'h0;

  // request kinds
  typedef enum logic [2:0] {
    PCC_MEM_RD = 3'h0,
    PCC_MEM_WR = 3'h1,
    PCC_ATTR_RD = 3'h2,
    PCC_ATTR_WR = 3'h3,
    PCC_IO_RD = 3'h4,
    PCC_IO_WR = 3'h5
  } pcc_kind_t;

  typedef struct packed {
    pcc_kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] lanes;
  } pcc_req_t;

  typedef struct packed {
    logic vcc_on;
    logic [1:0] vpp1_sel;
    logic [1:0] vpp2_sel;
  } pcc_power_t;

  typedef struct packed {
    logic present;
    logic battery_good;
    logic [1:0] battery_code;
    logic write_protect;
    logic card_busy;
    logic general_input;
    logic pins_owned;
    logic master_active;
  } pcc_status_t;

  // cycle state, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SETUP = 4'h2,
    ST_STROBE = 4'h4,
    ST_HOLD = 4'h8
  } pcc_state_t;

  // true for kinds that write to the card
  function automatic logic pcc_is_write(input pcc_kind_t k);
    return (k == PCC_MEM_WR) || (k == PCC_ATTR_WR) || (k == PCC_IO_WR);
  endfunction : pcc_is_write

  // true for kinds that reach attribute or io space
  function automatic logic pcc_is_reg(input pcc_kind_t k);
    return (k == PCC_ATTR_RD) || (k == PCC_ATTR_WR) || (k == PCC_IO_RD) || (k == PCC_IO_WR);
  endfunction : pcc_is_reg

  // true for io kinds
  function automatic logic pcc_is_io(input pcc_kind_t k);
    return (k == PCC_IO_RD) || (k == PCC_IO_WR);
  endfunction : pcc_is_io

endpackage : pcc_pkg

/* logic/pcc_pin_sync.sv */
`timescale 1ns/1ps
// three-stage pin synchroniser; output moves when stages two and three agree
module pcc_pin_sync
  import pcc_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;

  // shift chain; first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a bit only once two later stages agree
  always_ff @(posedge clk)
  begin
    if (reset)
      level_q <= RST;
    else
      level_q <= (s2_q & ~(s2_q ^ s3_q)) | (level_q & (s2_q ^ s3_q));
  end

  assign level_out = level_q;

endmodule : pcc_pin_sync

/* logic/pcc_socket.sv */
`timescale 1ns/1ps
module pcc_socket
  import pcc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  // strap and shared-pin arbitration
  input wire logic [1:0] strap_mode,
  input wire logic disk_pins_request,
  // user request and answer
  input wire logic req_valid,
  output logic req_ready,
  input wire pcc_pkg::pcc_req_t req,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [pcc_pkg::DATA_W-1:0] rsp_data,
  input wire logic card_reset_request,
  input wire pcc_pkg::pcc_power_t power_request,
  output pcc_pkg::pcc_status_t status,
  output logic [pcc_pkg::ADDR_W-1:0] master_addr,
  // card pins
  output logic card_reset,
  input wire logic [pcc_pkg::ADDR_W-1:0] card_addr_in,
  output logic [pcc_pkg::ADDR_W-1:0] card_addr_out,
  output logic card_addr_oe,
  input wire logic [pcc_pkg::DATA_W-1:0] card_data_in,
  output logic [pcc_pkg::DATA_W-1:0] card_data_out,
  output logic card_data_oe,
  output logic card_io_read_n,
  output logic card_io_write_n,
  output logic attr_select_n,
  output logic card_out_enable_n,
  output logic card_mem_write_gate_n,
  output logic even_byte_enable_n,
  output logic odd_byte_enable_n,
  output logic xcvr_direction,
  output logic addr_buffer_enable_n,
  output logic socket_activate_n,
  input wire logic card_wait_n,
  input wire logic card_ready_irq,
  input wire logic insert_detect_a_n,
  input wire logic insert_detect_b_n,
  input wire logic battery_sense_a,
  input wire logic battery_sense_b,
  input wire logic write_protect,
  input wire logic card_master_n,
  output logic vcc_enable_n,
  output logic prog_volt1_sel0,
  output logic prog_volt1_sel1,
  output logic prog_volt2_sel0,
  output logic prog_volt2_sel1
);

  logic [SYN_W-1:0] pins_raw;
  logic [SYN_W-1:0] pins_s;
  logic present;
  logic strap_taken_q;
  logic [1:0] strap_q;
  logic func_sel;
  logic own_q;
  logic master_q;
  pcc_state_t state_q;
  pcc_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  pcc_req_t cur_q;
  logic take;
  logic refuse;
  logic waiting;
  logic rsp_valid_q;
  logic rsp_error_q;
  logic [DATA_W-1:0] rsp_data_q;
  logic [ADDR_W-1:0] master_addr_q;
  logic card_reset_q;
  logic [ADDR_W-1:0] addr_out_q;
  logic addr_oe_q;
  logic [DATA_W-1:0] data_out_q;
  logic data_oe_q;
  logic card_io_read_n_n_q;
  logic card_io_write_n_n_q;
  logic attr_n_q;
  logic oe_n_q;
  logic we_n_q;
  logic ce_even_n_q;
  logic ce_odd_n_q;
  logic dir_q;
  logic buf_en_n_q;
  logic sock_n_q;
  pcc_power_t power_q;
  pcc_status_t status_q;

  // card status pins pass the three-stage filter
  assign pins_raw[SYN_WAIT] = card_wait_n;
  assign pins_raw[SYN_READY] = card_ready_irq;
  assign pins_raw[SYN_DET_A] = insert_detect_a_n;
  assign pins_raw[SYN_DET_B] = insert_detect_b_n;
  assign pins_raw[SYN_BAT_A] = battery_sense_a;
  assign pins_raw[SYN_BAT_B] = battery_sense_b;
  assign pins_raw[SYN_WP] = write_protect;
  assign pins_raw[SYN_MASTER] = card_master_n;

  pcc_pin_sync #(
    .W(SYN_W),
    .RST(SYN_RST)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .pin_in(pins_raw),
    .level_out(pins_s)
  );

  // both detect contacts low means a card is fully seated
  assign present = ~pins_s[SYN_DET_A] & ~pins_s[SYN_DET_B];

  // strap caught once, on the first clock after reset release
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      strap_taken_q <= 1'b0;
      strap_q <= STRAP_ISA;
    end
    else if (!strap_taken_q)
    begin
      strap_taken_q <= 1'b1;
      strap_q <= strap_mode;
    end
  end

  assign func_sel = strap_taken_q && (strap_q == STRAP_PCCARD);

  // shared pins: yield to the disk port only between card cycles
  always_ff @(posedge clk)
  begin
    if (reset)
      own_q <= 1'b0;
    else if (state_q == ST_IDLE)
      own_q <= func_sel && !disk_pins_request;
  end

  // card bus master takes the address pins while we are idle
  always_ff @(posedge clk)
  begin
    if (reset)
      master_q <= 1'b0;
    else if (state_q == ST_IDLE)
      master_q <= own_q && present && !pins_s[SYN_MASTER];
  end

  // request acceptance; refusals answer at once with an error
  assign req_ready = (state_q == ST_IDLE) && own_q && !master_q && !disk_pins_request;
  assign refuse = !present || (pcc_is_write(req.kind) && pins_s[SYN_WP]);
  assign take = req_valid && req_ready && !refuse;
  assign waiting = !pins_s[SYN_WAIT];

  // cycle sequencer: setup, strobe, hold
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE:
      begin
        if (take)
        begin
          state_d = ST_SETUP;
          cnt_d = CNT_W'(SETUP_CYC - 1);
        end
      end
      ST_SETUP:
      begin
        if (!present)
          state_d = ST_IDLE;
        else if (cnt_q == '0)
        begin
          state_d = ST_STROBE;
          cnt_d = CNT_W'(STROBE_CYC - 1);
        end
        else
          cnt_d = cnt_q - 1'b1;
      end
      ST_STROBE:
      begin
        if (!present)
          state_d = ST_IDLE;
        else if (cnt_q != '0)
          cnt_d = cnt_q - 1'b1;
        else if (!waiting)
        begin
          state_d = ST_HOLD;
          cnt_d = CNT_W'(HOLD_CYC - 1);
        end
      end
      ST_HOLD:
      begin
        if (cnt_q == '0)
          state_d = ST_IDLE;
        else
          cnt_d = cnt_q - 1'b1;
      end
      default:
      begin
        state_d = ST_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  // sequencer state and counter
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // request held for the length of the cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      cur_q <= '0;
    else if (take)
      cur_q <= req;
  end

  // answer: read data sampled as the strobe ends, error on refusal or on removal during setup or strobe
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rsp_valid_q <= 1'b0;
      rsp_error_q <= 1'b0;
      rsp_data_q <= '0;
    end
    else
    begin
      rsp_valid_q <= 1'b0;
      rsp_error_q <= 1'b0;
      if (req_valid && req_ready && refuse)
      begin
        rsp_valid_q <= 1'b1;
        rsp_error_q <= 1'b1;
      end
      else if ((state_q == ST_SETUP || state_q == ST_STROBE) && !present)
      begin
        rsp_valid_q <= 1'b1;
        rsp_error_q <= 1'b1;
      end
      else if (state_q == ST_HOLD && cnt_q == '0)
        rsp_valid_q <= 1'b1;
      if (state_q == ST_STROBE && state_d == ST_HOLD && !pcc_is_write(cur_q.kind))
        rsp_data_q <= card_data_in;
    end
  end

  // address pins: driven by us while we own the shared pins, except while a card masters the bus
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      addr_oe_q <= 1'b0;
      addr_out_q <= '0;
      master_addr_q <= '0;
    end
    else
    begin
      addr_oe_q <= own_q && !master_q;
      if (take)
        addr_out_q <= req.addr;
      if (master_q)
        master_addr_q <= card_addr_in;
    end
  end

  // data pins and transceiver direction follow the cycle in flight
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      data_oe_q <= 1'b0;
      data_out_q <= '0;
      dir_q <= 1'b0;
    end
    else
    begin
      if (take)
        data_out_q <= req.wdata;
      if (state_d != ST_IDLE && present)
      begin
        data_oe_q <= pcc_is_write(take ? req.kind : cur_q.kind);
        dir_q <= !pcc_is_write(take ? req.kind : cur_q.kind);
      end
      else
      begin
        data_oe_q <= 1'b0;
        dir_q <= 1'b0;
      end
    end
  end

  // strobes, attribute select and lane enables, registered from next state
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      card_io_read_n_n_q <= 1'b1;
      card_io_write_n_n_q <= 1'b1;
      attr_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      ce_even_n_q <= 1'b1;
      ce_odd_n_q <= 1'b1;
    end
    else if (state_d == ST_IDLE || !present)
    begin
      card_io_read_n_n_q <= 1'b1;
      card_io_write_n_n_q <= 1'b1;
      attr_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      ce_even_n_q <= 1'b1;
      ce_odd_n_q <= 1'b1;
    end
    else
    begin
      // memory space keeps select high, attribute and io pull it low
      attr_n_q <= !pcc_is_reg(take ? req.kind : cur_q.kind);
      ce_even_n_q <= !(take ? req.lanes[0] : cur_q.lanes[0]);
      ce_odd_n_q <= !(take ? req.lanes[1] : cur_q.lanes[1]);
      if (state_d == ST_STROBE)
      begin
        card_io_read_n_n_q <= !(cur_q.kind == PCC_IO_RD);
        card_io_write_n_n_q <= !(cur_q.kind == PCC_IO_WR);
        oe_n_q <= !(!pcc_is_io(cur_q.kind) && !pcc_is_write(cur_q.kind));
        we_n_q <= !(!pcc_is_io(cur_q.kind) && pcc_is_write(cur_q.kind));
      end
      else
      begin
        card_io_read_n_n_q <= 1'b1;
        card_io_write_n_n_q <= 1'b1;
        oe_n_q <= 1'b1;
        we_n_q <= 1'b1;
      end
    end
  end

  // card reset: on request, and held while the slot is empty
  always_ff @(posedge clk)
  begin
    if (reset)
      card_reset_q <= 1'b1;
    else
      card_reset_q <= card_reset_request || !present;
  end

  // socket and buffer select only once a card sits in the slot
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      buf_en_n_q <= 1'b1;
      sock_n_q <= 1'b1;
    end
    else
    begin
      buf_en_n_q <= !(present && own_q);
      sock_n_q <= !(present && own_q);
    end
  end

  // socket power: vcc dropped when the card leaves
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      power_q.vcc_on <= 1'b0;
      power_q.vpp1_sel <= VPP_OFF;
      power_q.vpp2_sel <= VPP_OFF;
    end
    else if (!present)
    begin
      power_q.vcc_on <= 1'b0;
      power_q.vpp1_sel <= VPP_OFF;
      power_q.vpp2_sel <= VPP_OFF;
    end
    else
      power_q <= power_request;
  end

  // status word for the user side
  always_ff @(posedge clk)
  begin
    if (reset)
      status_q <= '0;
    else
    begin
      status_q.present <= present;
      status_q.battery_good <= pins_s[SYN_BAT_A] & pins_s[SYN_BAT_B];
      status_q.battery_code <= {pins_s[SYN_BAT_B], pins_s[SYN_BAT_A]};
      status_q.write_protect <= pins_s[SYN_WP];
      status_q.card_busy <= present & ~pins_s[SYN_READY];
      status_q.general_input <= 1'b1;
      status_q.pins_owned <= own_q;
      status_q.master_active <= master_q;
    end
  end

  // outputs
  assign rsp_valid = rsp_valid_q;
  assign rsp_error = rsp_error_q;
  assign rsp_data = rsp_data_q;
  assign status = status_q;
  assign master_addr = master_addr_q;
  assign card_reset = card_reset_q;
  assign card_addr_out = addr_out_q;
  assign card_addr_oe = addr_oe_q;
  assign card_data_out = data_out_q;
  assign card_data_oe = data_oe_q;
  assign card_io_read_n = card_io_read_n_n_q;
  assign card_io_write_n = card_io_write_n_n_q;
  assign attr_select_n = attr_n_q;
  assign card_out_enable_n = oe_n_q;
  assign card_mem_write_gate_n = we_n_q;
  assign even_byte_enable_n = ce_even_n_q;
  assign odd_byte_enable_n = ce_odd_n_q;
  assign xcvr_direction = dir_q;
  assign addr_buffer_enable_n = buf_en_n_q;
  assign socket_activate_n = sock_n_q;
  // five power controls
  assign vcc_enable_n = power_q.vcc_on ? 1'b0 : VCC_OFF;
  assign prog_volt1_sel0 = power_q.vpp1_sel[0];
  assign prog_volt1_sel1 = power_q.vpp1_sel[1];
  assign prog_volt2_sel0 = power_q.vpp2_sel[0];
  assign prog_volt2_sel1 = power_q.vpp2_sel[1];

endmodule : pcc_socket

/* verification/pcc_socket_assertions.sv */
`timescale 1ns/1ps
// pin-level checks on the socket, bound into every socket instance
module pcc_socket_assertions
  import pcc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire pcc_pkg::pcc_req_t req,
  input wire logic rsp_valid,
  input wire logic rsp_error,
  input wire pcc_pkg::pcc_status_t status,
  input wire logic card_reset_request,
  input wire logic card_reset,
  input wire logic card_io_read_n,
  input wire logic card_io_write_n,
  input wire logic attr_select_n,
  input wire logic card_out_enable_n,
  input wire logic card_mem_write_gate_n,
  input wire logic even_byte_enable_n,
  input wire logic odd_byte_enable_n,
  input wire logic xcvr_direction,
  input wire logic socket_activate_n,
  input wire logic card_wait_n,
  input wire logic card_data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // taken request, write kind, and accepted take
  logic take, wr, ok;
  assign take = req_valid && req_ready && status.present;
  assign wr = req.kind inside {PCC_MEM_WR, PCC_ATTR_WR, PCC_IO_WR};
  assign ok = take && !(wr && status.write_protect);
  sequence s_wait;
    (!card_wait_n && !card_out_enable_n) [*6];
  endsequence
  property p_io_attr;
    !(card_io_read_n && card_io_write_n) |-> !attr_select_n;
  endproperty
  a_io_attr: assert property (p_io_attr) else $error("io strobe without attr select");
  property p_mem_attr;
    ok && req.kind inside {PCC_MEM_RD, PCC_MEM_WR} |=> attr_select_n [*8];
  endproperty
  a_mem_attr: assert property (p_mem_attr) else $error("attr select low in memory cycle");
  property p_dir;
    ok |=> xcvr_direction == !$past(wr);
  endproperty
  a_dir: assert property (p_dir) else $error("transceiver direction wrong");
  property p_lanes;
    ok |=> even_byte_enable_n == !$past(req.lanes[0]) && odd_byte_enable_n == !$past(req.lanes[1]);
  endproperty
  a_lanes: assert property (p_lanes) else $error("byte enables do not match lanes");
  property p_oe_read;
    !card_out_enable_n |-> xcvr_direction && !card_data_oe;
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("output enable outside read");
  property p_we_write;
    !card_mem_write_gate_n |-> !xcvr_direction && card_data_oe;
  endproperty
  a_we_write: assert property (p_we_write) else $error("write gate outside write");
  property p_wait;
    s_wait |=> !card_out_enable_n;
  endproperty
  a_wait: assert property (p_wait) else $error("read strobe ended during wait");
  property p_no_card;
    (!status.present) [*3] |-> !xcvr_direction && &{even_byte_enable_n, odd_byte_enable_n,
      card_io_read_n, card_io_write_n, card_out_enable_n, card_mem_write_gate_n, socket_activate_n};
  endproperty
  a_no_card: assert property (p_no_card) else $error("pins active with no card");
  property p_refuse;
    take && wr && status.write_protect |=> rsp_valid && rsp_error;
  endproperty
  a_refuse: assert property (p_refuse) else $error("protected write not refused");
  property p_reset;
    card_reset_request |=> card_reset;
  endproperty
  a_reset: assert property (p_reset) else $error("card reset not driven");
  property p_socket;
    (status.present && status.pins_owned) [*2] |-> !socket_activate_n;
  endproperty
  a_socket: assert property (p_socket) else $error("socket not selected");
  // main scenarios reached
  c_read: cover property (ok && !wr);
  c_write: cover property (ok && wr);
  c_wait: cover property (s_wait);
endmodule : pcc_socket_assertions

bind pcc_socket pcc_socket_assertions pcc_socket_assertions_i (.clk, .reset, .req_valid,
  .req_ready, .req, .rsp_valid, .rsp_error, .status, .card_reset_request, .card_reset,
  .card_io_read_n, .card_io_write_n, .attr_select_n, .card_out_enable_n, .card_mem_write_gate_n,
  .even_byte_enable_n, .odd_byte_enable_n, .xcvr_direction, .socket_activate_n, .card_wait_n,
  .card_data_oe);

/* verification/pcc_card_model.sv */
`timescale 1ns/1ps
// card in the socket: small word store, wait stretch, busy after memory and attribute writes
module pcc_card_model
  import pcc_pkg::*;
(
  input wire logic clk,
  input wire logic inserted,
  input wire logic half,
  input wire logic wp_sw,
  input wire logic [1:0] bat,
  input wire logic [3:0] wait_len,
  input wire logic master_on,
  input wire logic [pcc_pkg::ADDR_W-1:0] master_val,
  input wire logic [pcc_pkg::ADDR_W-1:0] card_addr_out,
  input wire logic [pcc_pkg::DATA_W-1:0] card_data_out,
  input wire logic card_io_read_n,
  input wire logic card_io_write_n,
  input wire logic attr_select_n,
  input wire logic card_out_enable_n,
  input wire logic card_mem_write_gate_n,
  output logic [pcc_pkg::ADDR_W-1:0] card_addr_in,
  output logic [pcc_pkg::DATA_W-1:0] card_data_in,
  output logic card_wait_n,
  output logic card_ready_irq,
  output logic insert_detect_a_n,
  output logic insert_detect_b_n,
  output logic battery_sense_a,
  output logic battery_sense_b,
  output logic write_protect,
  output logic card_master_n
);
  logic [DATA_W-1:0] mem [0:255] = '{default: '0};
  logic [15:0] cyc = '0;
  logic [7:0] wcnt = '0;
  logic [3:0] busy = '0;
  logic strobe_q = 1'b0;
  logic io_rd, io_wr, mem_rd, mem_wr, strobe;
  logic [7:0] idx;
  // io strobes count only while attribute select is low
  assign io_rd = !card_io_read_n && !attr_select_n;
  assign io_wr = !card_io_write_n && !attr_select_n;
  assign mem_rd = !card_out_enable_n;
  assign mem_wr = !card_mem_write_gate_n;
  assign strobe = io_rd || io_wr || mem_rd || mem_wr;
  assign idx = {(io_rd || io_wr) ? 2'h2 : {1'b0, !attr_select_n}, card_addr_out[5:0]};
  // released lines carry a moving pattern, never the last value
  assign card_data_in = (io_rd || mem_rd) ? mem[idx] : ~cyc;
  assign card_addr_in = master_on ? master_val : {~cyc, cyc[9:0]};
  // status pins of the card
  assign insert_detect_a_n = !inserted;
  assign insert_detect_b_n = !(inserted && !half);
  assign battery_sense_a = bat[0];
  assign battery_sense_b = bat[1];
  assign write_protect = wp_sw;
  assign card_master_n = !master_on;
  assign card_wait_n = (wcnt == 8'h0);
  assign card_ready_irq = (busy == 4'h0);
  // wait from each strobe start, store writes, busy after memory writes
  always_ff @(posedge clk)
  begin
    cyc <= cyc + 16'h1;
    strobe_q <= strobe;
    // wait outlasts the host's own strobe count, so it really stretches
    if (strobe && !strobe_q) wcnt <= (wait_len == 4'h0) ? 8'h0 : 8'(wait_len) + 8'h28;
    else if (wcnt != 8'h0) wcnt <= wcnt - 8'h1;
    if (mem_wr || io_wr) mem[idx] <= card_data_out;
    if (mem_wr) busy <= 4'ha;
    else if (busy != 4'h0) busy <= busy - 4'h1;
  end
endmodule : pcc_card_model

/* verification/test_pc_card_socket_interface.sv */
`timescale 1ns/1ps
module test_pc_card_socket_interface;
  import pcc_pkg::*;
  logic clk = 1'b0, reset = 1'b1, disk_pins_request = 1'b0, req_valid = 1'b0;
  logic card_reset_request = 1'b0, inserted = 1'b0, half = 1'b0, wp_sw = 1'b0, master_on = 1'b0;
  logic [1:0] strap_mode = STRAP_PCCARD, bat = 2'h3;
  logic [3:0] wait_len = 4'h0;
  logic [ADDR_W-1:0] master_val = '0;
  pcc_req_t req = '0;
  pcc_power_t power_request = '0;
  logic req_ready, rsp_valid, rsp_error, card_reset, card_addr_oe, card_data_oe;
  logic [DATA_W-1:0] rsp_data, card_data_in, card_data_out, d, got;
  logic [ADDR_W-1:0] master_addr, card_addr_in, card_addr_out;
  pcc_status_t status;
  logic card_io_read_n, card_io_write_n, attr_select_n, card_out_enable_n, card_mem_write_gate_n;
  logic even_byte_enable_n, odd_byte_enable_n, xcvr_direction, addr_buffer_enable_n;
  logic socket_activate_n, card_wait_n, card_ready_irq, insert_detect_a_n, insert_detect_b_n;
  logic battery_sense_a, battery_sense_b, write_protect, card_master_n, vcc_enable_n, got_err;
  logic prog_volt1_sel0, prog_volt1_sel1, prog_volt2_sel0, prog_volt2_sel1;
  logic [DATA_W-1:0] exp_mem [0:255] = '{default: '0};
  logic [5:0] a;
  pcc_kind_t k;
  int errors = 0, n_compared = 0, lat = 0;

  pcc_socket pcc_socket_i (.clk, .reset, .strap_mode, .disk_pins_request, .req_valid, .req_ready,
    .req, .rsp_valid, .rsp_error, .rsp_data, .card_reset_request, .power_request, .status,
    .master_addr, .card_reset, .card_addr_in, .card_addr_out, .card_addr_oe, .card_data_in,
    .card_data_out, .card_data_oe, .card_io_read_n, .card_io_write_n, .attr_select_n,
    .card_out_enable_n, .card_mem_write_gate_n, .even_byte_enable_n, .odd_byte_enable_n,
    .xcvr_direction, .addr_buffer_enable_n, .socket_activate_n, .card_wait_n, .card_ready_irq,
    .insert_detect_a_n, .insert_detect_b_n, .battery_sense_a, .battery_sense_b, .write_protect,
    .card_master_n, .vcc_enable_n, .prog_volt1_sel0, .prog_volt1_sel1, .prog_volt2_sel0,
    .prog_volt2_sel1);

  pcc_card_model pcc_card_model_i (.clk, .inserted, .half, .wp_sw, .bat, .wait_len, .master_on,
    .master_val, .card_addr_out, .card_data_out, .card_io_read_n, .card_io_write_n,
    .attr_select_n, .card_out_enable_n, .card_mem_write_gate_n, .card_addr_in, .card_data_in,
    .card_wait_n, .card_ready_irq, .insert_detect_a_n, .insert_detect_b_n, .battery_sense_a,
    .battery_sense_b, .write_protect, .card_master_n);

  // clock, 4 ns period
  initial
  begin
    forever #2 clk = ~clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // wait n edges, then move off the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // slot in the card store for a kind and address
  function automatic logic [7:0] key(input pcc_kind_t kk, input logic [5:0] aa);
    return {(kk >= PCC_IO_RD) ? 2'h2 : {1'b0, kk >= PCC_ATTR_RD}, aa};
  endfunction : key

  // one request: hold until taken, then count edges to the answer
  task automatic xfer(input pcc_kind_t kk, input logic [5:0] aa, input logic [15:0] dd);
    int n;
    n = 0;
    req = '{kind: kk, addr: {20'h0, aa}, wdata: dd, lanes: 2'(1 + $urandom % 3)};
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 500)
    begin
      step(1);
      n++;
    end
    step(1);
    req_valid = 1'b0;
    // lat counts edges from the take edge to the edge that samples the answer
    lat = 1;
    while (rsp_valid !== 1'b1 && lat < 500)
    begin
      step(1);
      lat++;
    end
    got = rsp_data;
    got_err = rsp_error;
  endtask : xfer

  // verdict and end of run
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // hang guard
  initial
  begin
    #100000;
    errors++;
    close_out();
  end

  // main sequence
  initial
  begin
    void'($urandom(32'hc463));
    step(6);
    reset = 1'b0;
    step(10);
    chk(card_reset, 1);
    xfer(PCC_MEM_RD, 6'h1, 16'h0);
    chk(got_err, 1);
    $display("test done: empty socket");
    inserted = 1'b1;
    half = 1'b1;
    step(10);
    chk(status.present, 0);
    half = 1'b0;
    step(10);
    chk(status.present, 1);
    chk(status.general_input, 1);
    chk({addr_buffer_enable_n, socket_activate_n}, 0);
    for (int b = 0; b < 4; b++)
    begin
      bat = 2'(b);
      step(8);
      chk(status.battery_good, b == 3);
      chk(status.battery_code, b);
    end
    power_request = 5'($urandom);
    step(3);
    chk({!vcc_enable_n, prog_volt1_sel1, prog_volt1_sel0, prog_volt2_sel1, prog_volt2_sel0},
      power_request);
    card_reset_request = 1'b1;
    step(2);
    chk(card_reset, 1);
    card_reset_request = 1'b0;
    step(2);
    chk(card_reset, 0);
    $display("test done: insertion and status");
    // every kind in turn, random address, data and wait
    for (int i = 0; i < 36; i++)
    begin
      k = pcc_kind_t'(i % 6);
      a = 6'($urandom % 8);
      d = 16'($urandom);
      wait_len = (i % 3 == 0) ? 4'(8 + $urandom % 8) : 4'h0;
      xfer(k, a, d);
      chk(got_err, 0);
      chk(status.card_busy, k inside {PCC_MEM_WR, PCC_ATTR_WR});
      if (wait_len == 4'h0) chk(lat, SETUP_CYC + STROBE_CYC + HOLD_CYC + 1);
      else chk(lat > SETUP_CYC + STROBE_CYC + HOLD_CYC + 1, 1);
      if (i % 2 == 1) exp_mem[key(k, a)] = d;
      else chk(got, exp_mem[key(k, a)]);
    end
    $display("test done: random traffic");
    wp_sw = 1'b1;
    step(8);
    chk(status.write_protect, 1);
    xfer(PCC_MEM_WR, 6'h2, 16'h5a5a);
    chk(got_err, 1);
    chk(lat, 1);
    wp_sw = 1'b0;
    step(8);
    xfer(PCC_MEM_RD, 6'h2, 16'h0);
    chk(got, exp_mem[key(PCC_MEM_RD, 6'h2)]);
    $display("test done: write protect");
    master_val = 26'($urandom);
    master_on = 1'b1;
    step(10);
    chk(card_addr_oe, 0);
    chk(master_addr, master_val);
    master_on = 1'b0;
    step(10);
    chk(card_addr_oe, 1);
    disk_pins_request = 1'b1;
    step(4);
    chk(req_ready, 0);
    chk(status.pins_owned, 0);
    disk_pins_request = 1'b0;
    step(4);
    chk(req_ready, 1);
    $display("test done: master and sharing");
    inserted = 1'b0;
    step(10);
    chk({even_byte_enable_n, odd_byte_enable_n, socket_activate_n, xcvr_direction, card_reset,
      vcc_enable_n}, 6'h3b);
    $display("test done: removal");
    close_out();
  end
endmodule : test_pc_card_socket_interface
